// File: rtl/ccr_regs.sv
/*
  Channel configuration and identity register bank with an APB slave, a
  channel sequencer and a setup store that feeds the converter configuration.
  Assumes an APB master in the CLK_SYS domain and a converter that takes the
  CONV_* outputs as its live configuration.
*/
// How it works
// - Identity register reads fixed code, ignores writes
// - Channel zero register, reset 0x8001
// - Bit 15 enables channel, resets enabled
// - Two or more enabled: sequencer steps automatically
// - Bits 14:12 pick one of eight setups
// - Setup's four words configure converter while converting
// - Bits 9:0 select input pair, reset 0x001
`timescale 1ns/1ps
module ccr_regs #(
   parameter logic [ccr_pkg::REG_W-1:0] PRODUCT_ID = ccr_pkg::PRODUCT_IDENTITY_VALUE  // Arbitrary value
) (
   input  wire logic                          CLK_SYS,
   input  wire logic                          RST,
   input  wire logic                          PSEL,
   input  wire logic                          PENABLE,
   input  wire logic                          PWRITE,
   input  wire logic [ccr_pkg::ADDR_W-1:0]    PADDR,
   input  wire logic [ccr_pkg::DATA_W-1:0]    PWDATA,
   output      logic [ccr_pkg::DATA_W-1:0]    PRDATA,
   output      logic                          PREADY,
   output      logic                          PSLVERR,
   output      logic                          CONV_ACTIVE,
   output      logic                          CONV_START,
   output      logic [ccr_pkg::CHAN_W-1:0]    CONV_CHANNEL,
   output      logic [ccr_pkg::SETUP_W-1:0]   CONV_SETUP,
   output      logic [ccr_pkg::PAIR_W-1:0]    CONV_INPUT_PAIR,
   output      logic [ccr_pkg::REG_W-1:0]     CONV_SETUP_CFG,
   output      logic [ccr_pkg::REG_W-1:0]     CONV_FILTER_CFG,
   output      logic [ccr_pkg::REG_W-1:0]     CONV_OFFSET,
   output      logic [ccr_pkg::REG_W-1:0]     CONV_GAIN
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [ccr_pkg::REG_W-1:0]   ch0_q;          // Channel zero configuration
   logic [ccr_pkg::REG_W-1:0]   peer_q;         // Enables of channels 7..1
   logic [ccr_pkg::IDX_W-1:0]   idx;            // Register index from PADDR
   logic                        acc;            // Access phase
   logic                        hit;            // Address is mapped
   logic                        wr_ack;         // Write takes effect this edge
   logic [ccr_pkg::REG_W-1:0]   rd_mux;         // Read data before the register
   logic [ccr_pkg::REG_W-1:0]   mem_rd_a;       // Setup word for the bus
   logic [ccr_pkg::REG_W-1:0]   mem_rd_b;       // Setup word for the sequencer
   logic [ccr_pkg::MEM_AW-1:0]  mem_raddr_b;    // Sequencer read address
   logic [ccr_pkg::NCH-1:0]     en_vec;         // One enable per channel
   logic [ccr_pkg::NCH-1:0]     en_prev_q;      // Enables one cycle back
   logic [ccr_pkg::CHAN_W-1:0]  nxt;            // Next channel to convert
   ccr_pkg::ccr_seq_t           state_q;        // Sequencer state
   logic [2:0]                  ld_cnt_q;       // Setup load step
   logic [7:0]                  dwell_q;        // Cycles spent converting

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // First enabled channel after cur, wrapping; cur itself is tried last
   function automatic logic [ccr_pkg::CHAN_W-1:0] next_chan(
      input logic [ccr_pkg::NCH-1:0]    en,
      input logic [ccr_pkg::CHAN_W-1:0] cur);
      logic [ccr_pkg::CHAN_W-1:0] c;
      logic [ccr_pkg::CHAN_W-1:0] n;
      c = cur;
      n = cur;
      for (int i = ccr_pkg::NCH; i >= 1; i--) begin
         c = cur + ccr_pkg::CHAN_W'(i);
         if (en[c]) begin
            n = c;
         end
      end
      return n;
   endfunction

   // Setup that a channel uses; only channel zero has a selector
   function automatic logic [ccr_pkg::SETUP_W-1:0] setup_of(
      input logic [ccr_pkg::CHAN_W-1:0] ch,
      input logic [ccr_pkg::REG_W-1:0]  cfg);
      return (ch == '0) ? cfg[ccr_pkg::CH0_SETUP_HI:ccr_pkg::CH0_SETUP_LO]
                        : ccr_pkg::SETUP_DEFAULT;
   endfunction

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   assign idx    = PADDR[ccr_pkg::IDX_LO +: ccr_pkg::IDX_W];
   assign acc    = PSEL & PENABLE;
   // Misaligned byte addresses fall outside the map
   assign hit    = (PADDR[ccr_pkg::IDX_LO-1:0] == '0) &
                   ((idx == ccr_pkg::IDX_PRODUCT_IDENTITY) | (idx == ccr_pkg::IDX_CHANNEL_ZERO) |
                    (idx == ccr_pkg::IDX_PEER_ENABLE) | idx[ccr_pkg::IDX_SETUP_BIT]);
   assign wr_ack = acc & PREADY & PWRITE & hit;
   assign en_vec = {peer_q[ccr_pkg::NCH-1:1], ch0_q[ccr_pkg::CH0_EN_BIT]};
   assign nxt    = next_chan(en_vec, CONV_CHANNEL);
   assign mem_raddr_b = {CONV_SETUP, ld_cnt_q[ccr_pkg::WORD_W-1:0]};

   // Read multiplexer; unmapped and reserved bits read zero
   always_comb begin
      rd_mux = '0;
      if (idx[ccr_pkg::IDX_SETUP_BIT]) begin
         rd_mux = mem_rd_a;
      end else if (idx == ccr_pkg::IDX_PRODUCT_IDENTITY) begin
         rd_mux = PRODUCT_ID;
      end else if (idx == ccr_pkg::IDX_CHANNEL_ZERO) begin
         rd_mux = ch0_q;
      end else if (idx == ccr_pkg::IDX_PEER_ENABLE) begin
         rd_mux = peer_q;
      end
   end

   // Every transfer waits one cycle so the setup store read can settle
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= acc & ~PREADY;
         if (acc & ~PREADY) begin
            // Refused addresses read zero, so a misaligned alias leaks nothing
            PRDATA  <= hit ? ccr_pkg::DATA_W'(rd_mux) : '0;
            PSLVERR <= ~hit;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Identity register has no storage, so writes to it simply vanish
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ch0_q  <= ccr_pkg::CH0_RESET;
         peer_q <= '0;
      end else if (wr_ack && idx == ccr_pkg::IDX_CHANNEL_ZERO) begin
         ch0_q  <= PWDATA[ccr_pkg::REG_W-1:0] & ccr_pkg::CH0_WMASK;
      end else if (wr_ack && idx == ccr_pkg::IDX_PEER_ENABLE) begin
         peer_q <= PWDATA[ccr_pkg::REG_W-1:0] & ccr_pkg::PEER_WMASK;
      end
   end

   // Enables one cycle back, for checking the sequencer's choice
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         en_prev_q <= '0;
      end else begin
         en_prev_q <= en_vec;
      end
   end

   // ---------------------------------------------------------------
   // Setup store
   // ---------------------------------------------------------------
   ccr_setup_mem u_setup_mem (
      .clk       (CLK_SYS),
      .rst       (RST),
      .wr_en     (wr_ack & idx[ccr_pkg::IDX_SETUP_BIT]),
      .wr_addr   (idx[ccr_pkg::MEM_AW-1:0]),
      .wr_data   (PWDATA[ccr_pkg::REG_W-1:0]),
      .rd_addr_a (idx[ccr_pkg::MEM_AW-1:0]),
      .rd_data_a (mem_rd_a),
      .rd_addr_b (mem_raddr_b),
      .rd_data_b (mem_rd_b)
   );

   // ---------------------------------------------------------------
   // Channel sequencer
   // ---------------------------------------------------------------
   // Selection is latched at channel entry; later edits apply on the next visit
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         state_q         <= ccr_pkg::S_IDLE;
         ld_cnt_q        <= '0;
         dwell_q         <= '0;
         CONV_START      <= 1'b0;
         CONV_ACTIVE     <= 1'b0;
         CONV_CHANNEL    <= '0;
         CONV_SETUP      <= '0;
         CONV_INPUT_PAIR <= ccr_pkg::PAIR_DEFAULT;
      end else begin
         CONV_START <= 1'b0;
         unique case (state_q)
            ccr_pkg::S_IDLE: begin
               // Leave idle as soon as any channel is enabled
               if (|en_vec) begin
                  state_q         <= ccr_pkg::S_LOAD;
                  ld_cnt_q        <= '0;
                  CONV_CHANNEL    <= nxt;
                  CONV_SETUP      <= setup_of(nxt, ch0_q);
                  CONV_INPUT_PAIR <= (nxt == '0) ? ch0_q[ccr_pkg::CH0_PAIR_HI:ccr_pkg::CH0_PAIR_LO]
                                                 : ccr_pkg::PAIR_DEFAULT;
               end
            end
            ccr_pkg::S_LOAD: begin
               // Four word reads of the chosen setup, then convert
               if (ld_cnt_q == ccr_pkg::LOAD_LAST) begin
                  state_q     <= ccr_pkg::S_CONV;
                  dwell_q     <= '0;
                  CONV_START  <= 1'b1;
                  CONV_ACTIVE <= 1'b1;
               end else begin
                  ld_cnt_q <= ld_cnt_q + 3'h1;
               end
            end
            ccr_pkg::S_CONV: begin
               if (dwell_q != ccr_pkg::CONV_LAST) begin
                  dwell_q <= dwell_q + 8'h01;
               end else if (|en_vec) begin
                  // Step to the next enabled channel with no software help
                  state_q         <= ccr_pkg::S_LOAD;
                  ld_cnt_q        <= '0;
                  CONV_ACTIVE     <= 1'b0;
                  CONV_CHANNEL    <= nxt;
                  CONV_SETUP      <= setup_of(nxt, ch0_q);
                  CONV_INPUT_PAIR <= (nxt == '0) ? ch0_q[ccr_pkg::CH0_PAIR_HI:ccr_pkg::CH0_PAIR_LO]
                                                 : ccr_pkg::PAIR_DEFAULT;
               end else begin
                  state_q     <= ccr_pkg::S_IDLE;
                  CONV_ACTIVE <= 1'b0;
               end
            end
         endcase
      end
   end

   // Capture setup words one read latency after each address
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         CONV_SETUP_CFG  <= '0;
         CONV_FILTER_CFG <= '0;
         CONV_OFFSET     <= '0;
         CONV_GAIN       <= '0;
      end else if (state_q == ccr_pkg::S_LOAD) begin
         unique case (ld_cnt_q)
            3'h1: CONV_SETUP_CFG  <= mem_rd_b;
            3'h2: CONV_FILTER_CFG <= mem_rd_b;
            3'h3: CONV_OFFSET     <= mem_rd_b;
            3'h4: CONV_GAIN       <= mem_rd_b;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   chk_id_read_value: assert property (
      (acc && !PWRITE && PREADY && idx == ccr_pkg::IDX_PRODUCT_IDENTITY && PADDR[ccr_pkg::IDX_LO-1:0] == '0)
      |-> PRDATA == ccr_pkg::DATA_W'(PRODUCT_ID)) else $error("identity read wrong");
   chk_ch0_write_store: assert property (
      (wr_ack && idx == ccr_pkg::IDX_CHANNEL_ZERO)
      |=> ch0_q == ($past(PWDATA[ccr_pkg::REG_W-1:0]) & ccr_pkg::CH0_WMASK)) else $error("channel write lost");
   chk_ch0_reset_val: assert property (
      ($past(RST) && $past(ch0_q) == ch0_q) |-> ch0_q == ccr_pkg::CH0_RESET) else $error("bad reset value");
   chk_pick_enabled: assert property (
      (state_q != ccr_pkg::S_CONV && $changed(CONV_CHANNEL)) |-> en_prev_q[CONV_CHANNEL])
      else $error("disabled channel picked");
   chk_seq_step_on: assert property (
      (state_q == ccr_pkg::S_CONV && dwell_q == ccr_pkg::CONV_LAST && $countones(en_vec) >= 2)
      |=> (state_q == ccr_pkg::S_LOAD && CONV_CHANNEL != $past(CONV_CHANNEL))) else $error("no step");
   chk_setup_latch: assert property (
      (state_q == ccr_pkg::S_LOAD && ld_cnt_q == 3'h0)
      |-> CONV_SETUP == setup_of(CONV_CHANNEL, $past(ch0_q))) else $error("setup select wrong");
   chk_load_length: assert property (
      (state_q == ccr_pkg::S_LOAD && ld_cnt_q == 3'h0)
      |-> ##5 (state_q == ccr_pkg::S_CONV && CONV_START && CONV_ACTIVE)) else $error("load length wrong");
   chk_load_address: assert property (
      (state_q == ccr_pkg::S_LOAD && ld_cnt_q < ccr_pkg::LOAD_LAST)
      |=> (state_q == ccr_pkg::S_LOAD && mem_rd_b == $past(u_setup_mem.mem_q[mem_raddr_b])))
      else $error("setup word misread");
   chk_pair_latch: assert property (
      (state_q == ccr_pkg::S_LOAD && ld_cnt_q == 3'h0 && CONV_CHANNEL == '0)
      |-> CONV_INPUT_PAIR == $past(ch0_q[ccr_pkg::CH0_PAIR_HI:ccr_pkg::CH0_PAIR_LO])) else $error("input pair wrong");
   chk_reserved_zero: assert property (
      ch0_q[ccr_pkg::CH0_RSV_HI:ccr_pkg::CH0_RSV_LO] == 2'h0) else $error("reserved bits set");

   cov_id_read:    cover property (acc && PREADY && !PWRITE && idx == ccr_pkg::IDX_PRODUCT_IDENTITY);
   cov_ch0_write:  cover property (wr_ack && idx == ccr_pkg::IDX_CHANNEL_ZERO);
   cov_two_chan:   cover property (CONV_START && CONV_CHANNEL != '0);
   cov_bad_addr:   cover property (acc && PREADY && PSLVERR);

endmodule

// File: inc/ccr_pkg.sv
/*
  Shared constants of the channel configuration register bank: APB register
  indices, field layout of the channel zero register, sequencer timing and
  the setup store geometry.
  Assumes a 100 MHz system clock and a 32-bit APB with byte addresses equal
  to four times the register index.
*/
package ccr_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;                   // APB byte address width
   localparam int DATA_W = 32;                  // APB data width
   localparam int REG_W  = 16;                  // Width of every register
   localparam int IDX_W  = 6;                   // Register index width
   localparam int IDX_LO = 2;                   // Index starts above byte lanes

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_PRODUCT_IDENTITY = 6'h07;
   localparam logic [IDX_W-1:0] IDX_CHANNEL_ZERO     = 6'h10;
   localparam logic [IDX_W-1:0] IDX_PEER_ENABLE      = 6'h11;
   localparam int               IDX_SETUP_BIT        = 5;    // Index bit that marks the setup window

   // Product code; value is arbitrary
   localparam logic [REG_W-1:0] PRODUCT_IDENTITY_VALUE = 16'h5A5A;

   // ---------------------------------------------------------------
   // Channel zero register layout
   // ---------------------------------------------------------------
   localparam logic [REG_W-1:0] CH0_RESET    = 16'h8001;
   localparam logic [REG_W-1:0] CH0_WMASK    = 16'hF3FF;      // Bits 11:10 never stored
   localparam int               CH0_EN_BIT   = 15;
   localparam int               CH0_SETUP_HI = 14;
   localparam int               CH0_SETUP_LO = 12;
   localparam int               CH0_RSV_HI   = 11;
   localparam int               CH0_RSV_LO   = 10;
   localparam int               CH0_PAIR_HI  = 9;
   localparam int               CH0_PAIR_LO  = 0;
   localparam logic [REG_W-1:0] PEER_WMASK   = 16'h00FE;      // Enables of channels 7..1

   // ---------------------------------------------------------------
   // Channels, setups and setup store
   // ---------------------------------------------------------------
   localparam int NCH       = 8;
   localparam int CHAN_W    = 3;
   localparam int SETUP_W   = 3;
   localparam int PAIR_W    = 10;
   localparam int WORD_W    = 2;                // Four words per setup
   localparam int MEM_AW    = SETUP_W + WORD_W;
   localparam int MEM_DEPTH = 1 << MEM_AW;
   localparam logic [SETUP_W-1:0] SETUP_DEFAULT = 3'h0;  // Setup used by channels 7..1
   localparam logic [PAIR_W-1:0]  PAIR_DEFAULT  = 10'h001;
   localparam logic [REG_W-1:0]   SETUP_WORD_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // Sequencer timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_NS  = 160;          // Dwell on one channel
   localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
   localparam logic [2:0] LOAD_LAST = 3'h4;     // Four addresses plus one read latency

   typedef enum logic [1:0] {S_IDLE, S_LOAD, S_CONV} ccr_seq_t;

endpackage

// File: rtl/ccr_setup_mem.sv
/*
  Setup store: eight setups of four 16-bit words each, one write port and two
  registered read ports (one for the bus, one for the sequencer).
  Assumes a single clock and an asynchronous active-high reset that clears it.
*/
`timescale 1ns/1ps
module ccr_setup_mem (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         wr_en,
   input  wire logic [ccr_pkg::MEM_AW-1:0]   wr_addr,
   input  wire logic [ccr_pkg::REG_W-1:0]    wr_data,
   input  wire logic [ccr_pkg::MEM_AW-1:0]   rd_addr_a,
   output      logic [ccr_pkg::REG_W-1:0]    rd_data_a,
   input  wire logic [ccr_pkg::MEM_AW-1:0]   rd_addr_b,
   output      logic [ccr_pkg::REG_W-1:0]    rd_data_b
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [ccr_pkg::REG_W-1:0] mem_q [ccr_pkg::MEM_DEPTH];   // Setup words

   // Write port; cleared on reset so every setup starts defined
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ccr_pkg::MEM_DEPTH; i++) begin
            mem_q[i] <= ccr_pkg::SETUP_WORD_RESET;
         end
      end else if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Registered read ports; a write shows on the next read edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_a <= ccr_pkg::SETUP_WORD_RESET;
         rd_data_b <= ccr_pkg::SETUP_WORD_RESET;
      end else begin
         rd_data_a <= mem_q[rd_addr_a];
         rd_data_b <= mem_q[rd_addr_b];
      end
   end

endmodule

// File: verif/ccr_regs_tb.sv
/*
  Self-checking bench for the channel configuration and identity register
  bank: APB reads and writes, setup selection and the channel sequencer.
  Assumes the design answers every APB transfer with one wait state and that
  the setup store sits at byte addresses 0x80..0xFC, four words per setup.
*/
`timescale 1ns/1ps
module ccr_regs_tb;
   // ---------------------------------------------------------------
   // Signals and counters
   // ---------------------------------------------------------------
   localparam int TIMEOUT_CYCLES = 20000;          // Generous ceiling, tests need under two thousand
   logic                               clk_sys;     // 100 MHz system clock
   logic                               rst;         // Asynchronous reset, active high
   logic                               psel;
   logic                               penable;
   logic                               pwrite;
   logic [ccr_pkg::ADDR_W-1:0]         paddr;
   logic [ccr_pkg::DATA_W-1:0]         pwdata;
   logic [ccr_pkg::DATA_W-1:0]         prdata;
   logic                               pready;
   logic                               pslverr;
   logic                               conv_active;
   logic                               conv_start;
   logic [ccr_pkg::CHAN_W-1:0]         conv_channel;
   logic [ccr_pkg::SETUP_W-1:0]        conv_setup;
   logic [ccr_pkg::PAIR_W-1:0]         conv_pair;
   logic [ccr_pkg::REG_W-1:0]          cfg_w [4];   // Setup, filter, offset, gain words
   logic [31:0]                        rd;          // Last read data
   logic                               err;         // Last error response
   logic [2:0]                         prev;        // Channel of the previous start
   logic [7:0]                         pats [4] = '{8'h07, 8'h06, 8'h81, 8'h10};
   int                                 num_errors  = 0;
   int                                 check_count = 0;
   int                                 cycles      = 0;

   ccr_regs dut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CONV_ACTIVE(conv_active), .CONV_START(conv_start), .CONV_CHANNEL(conv_channel),
      .CONV_SETUP(conv_setup), .CONV_INPUT_PAIR(conv_pair), .CONV_SETUP_CFG(cfg_w[0]),
      .CONV_FILTER_CFG(cfg_w[1]), .CONV_OFFSET(cfg_w[2]), .CONV_GAIN(cfg_w[3]));

   // ---------------------------------------------------------------
   // Clock and hang guard
   // ---------------------------------------------------------------
   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   // A stuck handshake ends here rather than running forever
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT_CYCLES) begin
         num_errors++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   // Single compare, counted; four-state equality so X matches only X
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One APB transfer; entered just after a rising edge, leaves one edge idle
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Request held until pready is sampled high
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   // Waits for the next conversion start; outputs are read as sampled at that edge
   task automatic wait_start();
      do @(posedge clk_sys); while (conv_start !== 1'b1);
   endtask

   // Next enabled channel after cur, ascending with wrap
   function automatic logic [2:0] nxt(input logic [7:0] en, input logic [2:0] cur);
      for (int i = 1; i <= 8; i++) begin
         if (en[3'(cur + i)]) return 3'(cur + i);
      end
      return cur;
   endfunction

   task automatic conclude();
      if (num_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      // Reset values and identity
      apb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0000_8001, "ch0 reset");
      apb(1'b0, 8'h1C, 32'h0); chk(rd, 32'(ccr_pkg::PRODUCT_IDENTITY_VALUE), "ident");
      apb(1'b1, 8'h1C, 32'h0000_1234); chk(32'(err), 32'h0, "ident wr err");
      apb(1'b0, 8'h1C, 32'h0); chk(rd, 32'(ccr_pkg::PRODUCT_IDENTITY_VALUE), "ident kept");
      apb(1'b0, 8'h18, 32'h0); chk({rd[30:0], err}, 32'h1, "unmapped");
      apb(1'b0, 8'h1D, 32'h0); chk({rd[30:0], err}, 32'h1, "misaligned");
      // First channel converts straight after reset
      wait_start(); chk(32'(conv_channel), 32'h0, "reset chan");
      chk(32'(conv_pair), 32'h0000_0001, "reset pair");
      // Every setup code, reserved bits written high
      for (int s = 0; s < 8; s++) begin
         for (int w = 0; w < 4; w++) apb(1'b1, 8'(8'h80 + (s * 4 + w) * 4), 32'(16'h0A00 + s * 16 + w));
         apb(1'b1, 8'h40, {16'h0, 1'b1, 3'(s), 2'b11, 10'(10'h010 + s)});
         apb(1'b0, 8'h40, 32'h0);
         chk(rd, {16'h0, 1'b1, 3'(s), 2'b00, 10'(10'h010 + s)}, "ch0 rdback");
         // Bus read of the setup store, first word of this setup
         apb(1'b0, 8'(8'h80 + s * 16), 32'h0);
         chk(rd, 32'(16'h0A00 + s * 16), "setup rdback");
         // Second start is sure to carry the edit
         wait_start();
         wait_start();
         chk(32'(conv_active), 32'h1, "active at start");
         chk(32'(conv_setup), 32'(s), "setup sel");
         chk(32'(conv_pair), 32'(10'h010 + s), "pair sel");
         for (int w = 0; w < 4; w++) chk(32'(cfg_w[w]), 32'(16'h0A00 + s * 16 + w), "setup word");
      end
      // Sequencing over several enable patterns, all sharing setup zero
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, 8'h40, {16'h0, pats[p][0], 15'h0001});
         apb(1'b1, 8'h44, {24'h0, pats[p] & 8'hFE});
         wait_start();
         wait_start();
         prev = conv_channel;
         for (int k = 0; k < 5; k++) begin
            wait_start();
            chk(32'(conv_channel), 32'(nxt(pats[p], prev)), "seq order");
            chk(32'(conv_setup), 32'h0, "shared setup");
            prev = conv_channel;
         end
      end
      // Nothing enabled: converter must fall idle
      apb(1'b1, 8'h40, 32'h0000_0001);
      apb(1'b1, 8'h44, 32'h0000_0000);
      repeat (60) @(posedge clk_sys);
      for (int k = 0; k < 30; k++) begin
         @(posedge clk_sys);
         chk(32'(conv_active), 32'h0, "idle");
      end
      // Mid-run reset: registers return to their reset values, channel zero restarts
      rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      apb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0000_8001, "ch0 after reset");
      apb(1'b0, 8'h44, 32'h0); chk(rd, 32'h0, "peers after reset");
      wait_start(); chk(32'(conv_channel), 32'h0, "restart chan");
      conclude();
   end
endmodule
